// *** rtl/rtt_cfg.svh ***
`ifndef RTT_CFG_SVH
`define RTT_CFG_SVH

// Register addresses in the device register bank
`define RTT_ADDR_CONTROL 8'h19
`define RTT_ADDR_RELOAD_HI 8'h1A
`define RTT_ADDR_RELOAD_LO 8'h1B
`define RTT_ADDR_COUNT_HI 8'h1C
`define RTT_ADDR_COUNT_LO 8'h1D

// Control field positions
`define RTT_BIT_HALT_RX 7
`define RTT_BIT_START_HI 5
`define RTT_BIT_START_LO 4
`define RTT_BIT_AUTO_RELOAD 3
`define RTT_BIT_CLK_HI 1
`define RTT_BIT_CLK_LO 0
`define RTT_CTRL_WMASK 8'hBB

// Reset values
`define RTT_CTRL_RESET 8'h00
`define RTT_RELOAD_RESET 8'h00

// Bits of a frame seen before the halt
`define RTT_RX_HALT_BITS 3'h4

// Timing: system clock period and fast/slow count clock periods
`define RTT_SYS_PERIOD_PS 10000
`define RTT_FAST_PERIOD_PS 73746
`define RTT_SLOW_PERIOD_PS 4716981
`define RTT_FAST_DIV (`RTT_FAST_PERIOD_PS / `RTT_SYS_PERIOD_PS)
`define RTT_SLOW_DIV (`RTT_SLOW_PERIOD_PS / `RTT_SYS_PERIOD_PS)

`endif

// *** rtl/rtt_pkg.sv ***
package rtt_pkg;

    typedef enum logic [1:0]
    {
        RTT_START_MANUAL = 2'h0,
        RTT_START_TX_END = 2'h1,
        RTT_START_TRIM_NOUF = 2'h2,
        RTT_START_TRIM_UF = 2'h3
    } rtt_start_t;

    typedef enum logic [1:0]
    {
        RTT_CLK_FAST = 2'h0,
        RTT_CLK_SLOW = 2'h1,
        RTT_CLK_TMR0 = 2'h2,
        RTT_CLK_TMR1 = 2'h3
    } rtt_clk_t;

    typedef struct packed
    {
        logic halt_on_receive;
        rtt_start_t start_mode_select;
        logic auto_reload_enable;
        rtt_clk_t count_clock_select;
    } rtt_ctrl_t;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtt_reg_req_t;

    typedef struct packed
    {
        logic tx_done;
        logic rx_bit;
        logic rx_active;
        logic osc_slow;
        logic tmr0_underflow;
        logic tmr1_underflow;
    } rtt_events_t;

endpackage : rtt_pkg

// *** rtl/rtt_tick_gen.sv ***
`timescale 1ns/1ps
`include "rtt_cfg.svh"

module rtt_tick_gen
    import rtt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    // Selection and sources
    input wire rtt_clk_t sel,
    input wire logic tmr0_underflow,
    input wire logic tmr1_underflow,
    // Count enable
    output logic tick
);

    localparam int FAST_DIV = (`RTT_FAST_DIV < 1) ? 1 : `RTT_FAST_DIV;
    localparam int SLOW_DIV = (`RTT_SLOW_DIV < 1) ? 1 : `RTT_SLOW_DIV;
    localparam logic [9:0] FAST_LAST = 10'(FAST_DIV - 1);
    localparam logic [9:0] SLOW_LAST = 10'(SLOW_DIV - 1);

    logic [9:0] fast_q, fast_d;
    logic [9:0] slow_q, slow_d;
    logic fast_tick;
    logic slow_tick;

    // Dividers run free so the fast and slow rates stay evenly spaced
    always_comb
    begin
        fast_tick = (fast_q == FAST_LAST);
        slow_tick = (slow_q == SLOW_LAST);
        fast_d = fast_tick ? 10'h000 : fast_q + 10'h001;
        slow_d = slow_tick ? 10'h000 : slow_q + 10'h001;
        unique case (sel)
            RTT_CLK_FAST: tick = fast_tick;
            RTT_CLK_SLOW: tick = slow_tick;
            RTT_CLK_TMR0: tick = tmr0_underflow;
            RTT_CLK_TMR1: tick = tmr1_underflow;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            fast_q <= 10'h000;
            slow_q <= 10'h000;
        end
        else
        begin
            fast_q <= fast_d;
            slow_q <= slow_d;
        end
    end

endmodule : rtt_tick_gen

// *** rtl/rtt_timer2.sv ***
`timescale 1ns/1ps
`include "rtt_cfg.svh"

// Summary of operation
// - Halt-on-receive stops timer after four received bits
// - Trimming start modes ignore halt-on-receive
// - Start mode 00b: only explicit start
// - Start mode 01b: start at transmit end
// - Mode 10b: oscillator trimming, no underflow
// - Mode 11b: oscillator trimming, underflow allowed
// - Auto reload on zero, keep counting
// - No auto reload: count to zero, stop
// - Every underflow sets the interrupt flag
// - Clock select 00b fast, 01b slow
// - Clock select 10b/11b cascade on underflows
// - Start loads the 16-bit reload value
// - Reload writes reach the count only at next start or auto reload
// - Live count readable as two bytes
module rtt_timer2
    import rtt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire rtt_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Software start and stop strobes
    input wire logic sw_start,
    input wire logic sw_stop,
    // Events from the rest of the chip
    input wire rtt_events_t events,
    // Timer state
    output logic running,
    output logic underflow,
    output logic second_timer_underflow_flag
);

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } rtt_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    // Reset drops at once but leaves on a clock edge, two flops deep
    logic rst_m_q;
    logic rst_sync_n;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_m_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_sync_n <= rst_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    rtt_ctrl_t ctrl_q, ctrl_d;
    logic [7:0] reload_hi_q, reload_hi_d;
    logic [7:0] reload_lo_q, reload_lo_d;
    logic [7:0] rdata_d;
    logic [15:0] count_q, count_d;

    // Unpacks a control byte; reserved bits 6 and 2 are never stored
    function automatic rtt_ctrl_t ctrl_from_byte(input logic [7:0] b);
        rtt_ctrl_t c;
        c.halt_on_receive = b[`RTT_BIT_HALT_RX];
        c.start_mode_select = rtt_start_t'(b[`RTT_BIT_START_HI:`RTT_BIT_START_LO]);
        c.auto_reload_enable = b[`RTT_BIT_AUTO_RELOAD];
        c.count_clock_select = rtt_clk_t'(b[`RTT_BIT_CLK_HI:`RTT_BIT_CLK_LO]);
        return c;
    endfunction : ctrl_from_byte

    function automatic logic wr_hit(input rtt_reg_req_t r, input logic [7:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction : wr_hit

    function automatic logic [7:0] ctrl_byte(input rtt_ctrl_t c);
        ctrl_byte = {c.halt_on_receive, 1'b0, c.start_mode_select, c.auto_reload_enable, 1'b0,
                     c.count_clock_select};
    endfunction : ctrl_byte

    // Count bytes are read live with no latch; a borrow between the two
    // byte reads can tear the pair, so read them with the timer stopped
    function automatic logic [7:0] read_byte(input logic [7:0] a, input rtt_ctrl_t c, input logic [7:0] hi,
                                             input logic [7:0] lo, input logic [15:0] cnt);
        unique case (a)
            `RTT_ADDR_CONTROL: read_byte = ctrl_byte(c) & `RTT_CTRL_WMASK;
            `RTT_ADDR_RELOAD_HI: read_byte = hi;
            `RTT_ADDR_RELOAD_LO: read_byte = lo;
            `RTT_ADDR_COUNT_HI: read_byte = cnt[15:8];
            `RTT_ADDR_COUNT_LO: read_byte = cnt[7:0];
            default: read_byte = 8'h00;
        endcase
    endfunction : read_byte

    always_comb
    begin
        ctrl_d = ctrl_q;
        reload_hi_d = reload_hi_q;
        reload_lo_d = reload_lo_q;
        if (reg_req.wr)
        begin
            unique case (reg_req.addr)
                `RTT_ADDR_CONTROL: ctrl_d = ctrl_from_byte(reg_req.wdata);
                // Reload bytes never touch the running count
                `RTT_ADDR_RELOAD_HI: reload_hi_d = reg_req.wdata;
                `RTT_ADDR_RELOAD_LO: reload_lo_d = reg_req.wdata;
                default: ;
            endcase
        end
        // Read data holds until the next read
        rdata_d = reg_rdata;
        if (reg_req.rd)
            rdata_d = read_byte(reg_req.addr, ctrl_q, reload_hi_q, reload_lo_q, count_q);
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ctrl_q <= ctrl_from_byte(`RTT_CTRL_RESET);
            reload_hi_q <= `RTT_RELOAD_RESET;
            reload_lo_q <= `RTT_RELOAD_RESET;
            reg_rdata <= 8'h00;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            reload_hi_q <= reload_hi_d;
            reload_lo_q <= reload_lo_d;
            reg_rdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count clock

    logic tick;

    // Cascade sources arrive as one-cycle pulses
    rtt_tick_gen u_tick
    (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .sel(ctrl_q.count_clock_select),
        .tmr0_underflow(events.tmr0_underflow),
        .tmr1_underflow(events.tmr1_underflow),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Start and stop events

    logic osc_prev_q, osc_prev_d;
    logic [2:0] rx_bits_q, rx_bits_d;
    logic trim_mode;
    logic osc_rise;
    logic start_evt;
    logic rx_halt_evt;
    logic trim_stop_evt;

    always_comb
    begin
        // Both trimming modes share the top bit of the start mode
        trim_mode = ctrl_q.start_mode_select[1];
        osc_rise = events.osc_slow & ~osc_prev_q;
        osc_prev_d = events.osc_slow;
        // Counts bits of the current frame, saturating at the halt point
        rx_bits_d = rx_bits_q;
        if (!events.rx_active)
            rx_bits_d = 3'h0;
        else if (events.rx_bit && rx_bits_q != `RTT_RX_HALT_BITS)
            rx_bits_d = rx_bits_q + 3'h1;
        // Halt on the fourth bit itself, not a cycle after it
        rx_halt_evt = ctrl_q.halt_on_receive && !trim_mode
                      && events.rx_active && events.rx_bit
                      && rx_bits_q == (`RTT_RX_HALT_BITS - 3'h1);
        // Explicit start works in every mode
        start_evt = sw_start;
        trim_stop_evt = 1'b0;
        unique case (ctrl_q.start_mode_select)
            RTT_START_MANUAL: ;
            RTT_START_TX_END: start_evt = sw_start | events.tx_done;
            RTT_START_TRIM_NOUF, RTT_START_TRIM_UF:
            begin
                // First rising edge starts, the next one stops
                start_evt = sw_start | (osc_rise & ~running);
                trim_stop_evt = osc_rise & running;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event state

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            osc_prev_q <= 1'b0;
            rx_bits_q <= 3'h0;
        end
        else
        begin
            osc_prev_q <= osc_prev_d;
            rx_bits_q <= rx_bits_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter

    rtt_state_t state_q, state_d;
    logic flag_d;
    logic underflow_d;
    logic [15:0] reload_value;
    logic count_zero;
    logic stop_req;
    logic uf_allowed;

    always_comb
    begin
        reload_value = {reload_hi_q, reload_lo_q};
        count_zero = (count_q == 16'h0000);
        // Halt, trim edge or software: all end the count at once
        stop_req = sw_stop || rx_halt_evt || trim_stop_evt;
        // Only trimming without underflow lets the count end silently
        uf_allowed = (ctrl_q.start_mode_select != RTT_START_TRIM_NOUF);
        state_d = state_q;
        count_d = count_q;
        underflow_d = 1'b0;
        flag_d = second_timer_underflow_flag;
        unique case (state_q)
            ST_IDLE:
            begin
                if (start_evt)
                begin
                    count_d = reload_value;
                    state_d = ST_RUN;
                end
            end
            ST_RUN:
            begin
                // Stop wins over a tick in the same cycle
                if (stop_req)
                    state_d = ST_IDLE;
                else if (tick)
                begin
                    if (!count_zero)
                        count_d = count_q - 16'h0001;
                    else if (!uf_allowed)
                        state_d = ST_IDLE;
                    else
                    begin
                        underflow_d = 1'b1;
                        if (ctrl_q.auto_reload_enable)
                            count_d = reload_value;
                        else
                            state_d = ST_IDLE;
                    end
                end
            end
            // Illegal state code: fall back to idle
            default: state_d = ST_IDLE;
        endcase
        // Software clears the flag by writing the reload high byte;
        // an underflow in the same cycle still sets it
        if (wr_hit(reg_req, `RTT_ADDR_RELOAD_HI))
            flag_d = 1'b0;
        if (underflow_d)
            flag_d = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_q <= ST_IDLE;
            count_q <= 16'h0000;
            running <= 1'b0;
            underflow <= 1'b0;
            second_timer_underflow_flag <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            count_q <= count_d;
            running <= (state_d == ST_RUN);
            underflow <= underflow_d;
            second_timer_underflow_flag <= flag_d;
        end
    end

endmodule : rtt_timer2

// *** bench/rtt_timer2_asserts.sv ***
`timescale 1ns/1ps
`include "rtt_cfg.svh"

module rtt_timer2_chk
    import rtt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire rtt_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // Strobes and events
    input wire logic sw_start,
    input wire logic sw_stop,
    input wire rtt_events_t events,
    // Timer state
    input wire logic running,
    input wire logic underflow,
    input wire logic second_timer_underflow_flag
);
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [2:0] nb_q;
    logic [2:0] nb_d;

    // Shadow of control byte, bits seen in current frame
    always_comb
    begin
        ctl_d = ctl_q;
        // Saturates at four so a long frame cannot wrap into a false halt
        nb_d = !events.rx_active ? 3'h0 : (events.rx_bit && nb_q != 3'h4) ? nb_q + 3'h1 : nb_q;
        if (reg_req.wr && reg_req.addr == `RTT_ADDR_CONTROL)
        begin
            ctl_d = reg_req.wdata & `RTT_CTRL_WMASK;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_q <= 8'h00;
            nb_q <= 3'h0;
        end
        else
        begin
            ctl_q <= ctl_d;
            nb_q <= nb_d;
        end
    end

    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Halt may lag one cycle if the bit count is registered
    sequence s_fourth_bit;
        running && ctl_q[7] && !ctl_q[5] && events.rx_active && events.rx_bit && nb_q == 3'h3;
    endsequence

    AST_HALT_RX: assert property (s_fourth_bit |-> ##[1:2] !running)
        else $error("halt after fourth bit missed");
    AST_SW_START: assert property (sw_start && !sw_stop && !running |=> running)
        else $error("explicit start ignored");
    AST_NO_SELF_START: assert property (!running && !sw_start && ctl_q[5:4] == 2'h0 |=> !running)
        else $error("timer started on its own");
    AST_TX_START: assert property (events.tx_done && !running && !sw_stop && ctl_q[5:4] == 2'h1 |-> ##[1:2] running)
        else $error("no start at transmit end");
    AST_TRIM_NO_UF: assert property (ctl_q[5:4] == 2'h2 |=> !underflow)
        else $error("underflow while trimming");
    AST_AUTO_KEEP: assert property (underflow && ctl_q[3] && !ctl_q[5] |-> running)
        else $error("auto reload did not continue");
    AST_ONCE_STOP: assert property (underflow && !ctl_q[3] && !ctl_q[5] |-> ##[0:1] !running)
        else $error("timer kept running after underflow");
    AST_IDLE_NO_UF: assert property (!running |=> !underflow)
        else $error("underflow while idle");
    AST_UF_FLAG: assert property (underflow |-> second_timer_underflow_flag)
        else $error("underflow flag not set");
    AST_RD_HOLD: assert property (!reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
    AST_CTRL_RD: assert property (reg_req.rd && reg_req.addr == 8'h19 |=> reg_rdata == $past(ctl_q))
        else $error("control readback wrong");
endmodule : rtt_timer2_chk

bind rtt_timer2 rtt_timer2_chk u_chk
(
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .sw_start(sw_start), .sw_stop(sw_stop), .events(events), .running(running),
    .underflow(underflow), .second_timer_underflow_flag(second_timer_underflow_flag)
);

// *** bench/tb_top.sv ***
`timescale 1ns/1ps

module tb_top
    import rtt_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sw_start = 1'b0;
    logic sw_stop = 1'b0;
    rtt_reg_req_t req = '0;
    rtt_events_t ev = '0;
    logic [7:0] rdata;
    logic run, uf, flag;
    logic rd_seen = 1'b0;
    logic [7:0] expq[$];
    logic [31:0] seed = 32'h000015A1;
    logic [15:0] c;
    logic [7:0] h, l;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    wire [15:0] st = {14'h0000, run, flag};

    rtt_timer2 dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata), .sw_start(sw_start),
        .sw_stop(sw_stop), .events(ev), .running(run), .underflow(uf), .second_timer_underflow_flag(flag));

    always #5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp_rd

    task automatic cmp_st(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp_st

    task automatic test_done();
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // Read data stands until the next read, so sample at the falling edge
    always @(posedge clk_sys)
    begin
        rd_seen <= req.rd;
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            test_done();
        end
    end

    always @(negedge clk_sys)
    begin
        if (rd_seen)
        begin
            cmp_rd(rdata, expq.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk_sys);
        req.wr = 1'b0;
    endtask : wr

    // Never called while a frame is coming in
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        req.rd = 1'b1;
        req.addr = a;
        expq.push_back(e);
        @(negedge clk_sys);
        req.rd = 1'b0;
    endtask : rd

    task automatic go(input logic s);
        @(negedge clk_sys);
        sw_start = s;
        sw_stop = !s;
        @(negedge clk_sys);
        sw_start = 1'b0;
        sw_stop = 1'b0;
        @(negedge clk_sys);
    endtask : go

    task automatic tick(input logic t1, input int n);
        repeat (n)
        begin
            @(negedge clk_sys);
            ev.tmr0_underflow = !t1;
            ev.tmr1_underflow = t1;
            @(negedge clk_sys);
            ev.tmr0_underflow = 1'b0;
            ev.tmr1_underflow = 1'b0;
        end
        repeat (2) @(negedge clk_sys);
    endtask : tick

    task automatic frame();
        ev.rx_active = 1'b1;
        repeat (4)
        begin
            @(negedge clk_sys);
            ev.rx_bit = 1'b1;
            @(negedge clk_sys);
            ev.rx_bit = 1'b0;
        end
        repeat (2) @(negedge clk_sys);
        ev.rx_active = 1'b0;
    endtask : frame

    task automatic osc();
        @(negedge clk_sys);
        ev.osc_slow = 1'b1;
        repeat (3) @(negedge clk_sys);
        ev.osc_slow = 1'b0;
        @(negedge clk_sys);
    endtask : osc

    task automatic wuf(output logic [15:0] n);
        n = 16'h0000;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (uf !== 1'b1 && n < 16'h03E8);
    endtask : wuf

    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        rd(8'h19, 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h19, 8'hFF);
        rd(8'h19, 8'hBB);
        void'(rnd());
        h = seed[15:8];
        l = {5'h00, seed[2:0]} + 8'h02;
        wr(8'h19, 8'h02);
        wr(8'h1A, h);
        wr(8'h1B, l);
        rd(8'h1B, l);
        go(1'b1);
        rd(8'h1C, h);
        tick(1'b0, 2);
        tick(1'b1, 3);
        wr(8'h1B, 8'hFF);
        rd(8'h1D, l - 8'h02);
        go(1'b0);
        wr(8'h1A, 8'h00);
        wr(8'h1B, 8'h03);
        go(1'b1);
        tick(1'b0, 3);
        cmp_st(st, 16'h0002);
        tick(1'b0, 1);
        cmp_st(st, 16'h0001);
        wr(8'h1A, 8'h00);
        wr(8'h19, 8'h0B);
        wr(8'h1B, 8'h02);
        go(1'b1);
        tick(1'b1, 3);
        tick(1'b0, 2);
        rd(8'h1D, 8'h02);
        cmp_st(st, 16'h0003);
        go(1'b0);
        for (int m = 0; m < 2; m++)
        begin
            wr(8'h19, m ? 8'h12 : 8'h02);
            @(negedge clk_sys);
            ev.tx_done = 1'b1;
            @(negedge clk_sys);
            ev.tx_done = 1'b0;
            repeat (2) @(negedge clk_sys);
            cmp_st(st, m ? 16'h0003 : 16'h0001);
        end
        for (int m = 0; m < 2; m++)
        begin
            go(1'b0);
            wr(8'h19, m ? 8'h82 : 8'h02);
            go(1'b1);
            frame();
            cmp_st(st, m ? 16'h0001 : 16'h0003);
        end
        wr(8'h1A, 8'h00);
        wr(8'h1B, 8'h01);
        wr(8'h19, 8'hA2);
        osc();
        frame();
        cmp_st(st, 16'h0002);
        tick(1'b0, 3);
        cmp_st(16'(flag), 16'h0000);
        wr(8'h19, 8'hB2);
        osc();
        tick(1'b0, 3);
        cmp_st(16'(flag), 16'h0001);
        go(1'b0);
        wr(8'h1A, 8'h00);
        wr(8'h1B, 8'h00);
        wr(8'h19, 8'h08);
        go(1'b1);
        wuf(c);
        wuf(c);
        cmp_st(c, 16'h0007);
        wr(8'h19, 8'h09);
        wuf(c);
        wuf(c);
        cmp_st(c, 16'h01D7);
        test_done();
    end
endmodule : tb_top
